// ===== hdl/low_region_supported_pkg.sv
// package: register map, field layout and carriers for the protected low region
package low_region_supported_pkg;
   localparam int unsigned LOW_REGION_SUPPORTED_DATA_W = 32;
   localparam int unsigned LOW_REGION_SUPPORTED_ADDR_W = 12;
   // register byte offsets
   localparam logic [11:0] LOW_REGION_SUPPORTED_OFF_ENABLE = 12'h064;
   localparam logic [11:0] LOW_REGION_SUPPORTED_OFF_BASE = 12'h068;
   localparam logic [11:0] LOW_REGION_SUPPORTED_OFF_LIMIT = 12'h06C;
   localparam logic [11:0] LOW_REGION_SUPPORTED_OFF_CAP = 12'h080;
   // field positions
   localparam int unsigned LOW_REGION_SUPPORTED_EN_ON_BIT = 31;
   localparam int unsigned LOW_REGION_SUPPORTED_EN_STS_BIT = 0;
   localparam int unsigned LOW_REGION_SUPPORTED_CAP_LOW_BIT = 0;
   localparam int unsigned LOW_REGION_SUPPORTED_CAP_REMAP_BIT = 1;
   // default alignment: bits N:0 reserved
   localparam int unsigned LOW_REGION_SUPPORTED_RSVD_N = 20;
   localparam logic [31:0] LOW_REGION_SUPPORTED_RESET_VAL = 32'h0000_0000;

   // dma request carrier
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } low_region_supported_dma_req_t;

   // dma verdict carrier
   typedef struct packed {
      logic valid;
      logic blocked;
   } low_region_supported_dma_rsp_t;
endpackage : low_region_supported_pkg

// ===== hdl/low_region_supported_region.sv
// protected low-memory region registers, decode and dma check
//
// Contract
// RQ1: software programs base and limit before switching protected memory on.
// RQ2: software leaves base and limit alone while the status bit shows regions enabled.
// RQ3: without low-region support both region registers are read-only and ignore writes.
// RQ4: bits N:0 read as zero, so writing all ones reveals N.
// RQ5: the decoded base takes bits N:0 as zeros.
// RQ6: the decoded limit takes bits N:0 as ones, an inclusive last address.
// RQ7: software keeps the region below the 4GB boundary.
// RQ8: equal upper bits of base and limit give a region of 2 to the power N+1 bytes.
// RQ9: a limit below the base disables the region.
// RQ10: the base register at 068h holds a field in bits 31:(N+1), reset zero.
// RQ11: the limit register at 06Ch holds a field in bits 31:(N+1), reset zero.
// RQ12: with protection on and remapping off every dma hit on the region is blocked.
// RQ13: status bit 0 of the enable register reads 1 while protection is in force.
// RQ14: an address hits when it lies between decoded base and limit inclusive.
`timescale 1ns/1ps
module low_region_supported_region
#(
   parameter int unsigned RSVD_N = low_region_supported_pkg::LOW_REGION_SUPPORTED_RSVD_N,
   parameter bit LOW_SUPPORTED = 1'b1
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [low_region_supported_pkg::LOW_REGION_SUPPORTED_ADDR_W-1:0] paddr,
   input wire logic [low_region_supported_pkg::LOW_REGION_SUPPORTED_DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [low_region_supported_pkg::LOW_REGION_SUPPORTED_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // remapping state from the translation unit, same clock
   input wire logic remap_on,
   // dma check
   input wire low_region_supported_pkg::low_region_supported_dma_req_t dma_req,
   output low_region_supported_pkg::low_region_supported_dma_rsp_t dma_rsp
);
   import low_region_supported_pkg::*;

   localparam logic [31:0] RSVD_MASK = 32'(({32'h0, 1'b1} << (RSVD_N + 1)) - 33'h1);
   localparam logic [31:0] FIELD_MASK = ~RSVD_MASK;
   localparam int unsigned ON_LANE = LOW_REGION_SUPPORTED_EN_ON_BIT / 8;

   logic [31:0] base_q;
   logic [31:0] base_d;
   logic [31:0] limit_q;
   logic [31:0] limit_d;
   logic on_q;
   logic on_d;
   logic sts_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic ready_q;
   logic slverr_q;
   logic slverr_d;
   low_region_supported_dma_rsp_t rsp_q;
   low_region_supported_dma_rsp_t rsp_d;

   // bus decode; reads fetch in setup, writes land with pready
   wire setup_w = psel && !penable;
   wire access_w = psel && penable && ready_q;
   wire wr_w = access_w && pwrite;
   wire rd_w = setup_w && !pwrite;
   wire hit_en = (paddr == LOW_REGION_SUPPORTED_OFF_ENABLE);
   wire hit_base = (paddr == LOW_REGION_SUPPORTED_OFF_BASE);
   wire hit_limit = (paddr == LOW_REGION_SUPPORTED_OFF_LIMIT);
   wire hit_cap = (paddr == LOW_REGION_SUPPORTED_OFF_CAP);
   wire mapped_w = hit_en || hit_base || hit_limit || hit_cap;
   wire regs_writable = LOW_SUPPORTED; // RQ3

   // byte-lane merge
   wire [31:0] strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   wire [31:0] base_merge = (base_q & ~strb_mask) | (pwdata & strb_mask);
   wire [31:0] limit_merge = (limit_q & ~strb_mask) | (pwdata & strb_mask);

   // register next values; low bits forced to zero
   assign base_d = (wr_w && hit_base && regs_writable) ? (base_merge & FIELD_MASK) : base_q; // RQ3 RQ4 RQ10
   assign limit_d = (wr_w && hit_limit && regs_writable) ? (limit_merge & FIELD_MASK) : limit_q; // RQ3 RQ4 RQ11
   assign on_d = (wr_w && hit_en && pstrb[ON_LANE]) ? pwdata[LOW_REGION_SUPPORTED_EN_ON_BIT] : on_q;

   // readback
   wire [31:0] en_rd = ({31'h0, on_q} << LOW_REGION_SUPPORTED_EN_ON_BIT) | ({31'h0, sts_q} << LOW_REGION_SUPPORTED_EN_STS_BIT); // RQ13
   wire [31:0] cap_rd = ({31'h0, regs_writable} << LOW_REGION_SUPPORTED_CAP_LOW_BIT)
      | ({31'h0, remap_on} << LOW_REGION_SUPPORTED_CAP_REMAP_BIT);
   assign rdata_d = !rd_w ? rdata_q :
      hit_en ? en_rd :
      hit_base ? base_q :
      hit_limit ? limit_q :
      hit_cap ? cap_rd : 32'h0000_0000;
   assign slverr_d = setup_w && !mapped_w;

   // region decode
   wire [31:0] dec_base = base_q & FIELD_MASK; // RQ5
   wire [31:0] dec_limit = limit_q | RSVD_MASK; // RQ6 RQ8
   wire region_en = (limit_q >= base_q); // RQ9
   wire in_region = (dma_req.addr >= dec_base) && (dma_req.addr <= dec_limit); // RQ14
   wire block_w = sts_q && !remap_on && region_en && in_region; // RQ12

   always_comb
   begin
      rsp_d.valid = dma_req.valid;
      rsp_d.blocked = dma_req.valid && block_w; // RQ12
   end

   // aligned base
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         base_q <= LOW_REGION_SUPPORTED_RESET_VAL;
      end
      else
      begin
         base_q <= base_d; // RQ10
      end
   end

   // aligned limit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         limit_q <= LOW_REGION_SUPPORTED_RESET_VAL;
      end
      else
      begin
         limit_q <= limit_d; // RQ11
      end
   end

   // protection switch
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         on_q <= 1'b0;
      end
      else
      begin
         on_q <= on_d;
      end
   end

   // status lags the switch by one cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sts_q <= 1'b0;
      end
      else
      begin
         sts_q <= on_q; // RQ13
      end
   end

   // read data, held until the next read
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdata_q <= LOW_REGION_SUPPORTED_RESET_VAL;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   // ready for exactly the access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ready_q <= 1'b0;
      end
      else
      begin
         ready_q <= setup_w;
      end
   end

   // error only beside ready
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         slverr_q <= 1'b0;
      end
      else
      begin
         slverr_q <= slverr_d;
      end
   end

   // dma verdict, one cycle after the request
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rsp_q <= '0;
      end
      else
      begin
         rsp_q <= rsp_d;
      end
   end

   assign prdata = rdata_q;
   assign pready = ready_q;
   assign pslverr = slverr_q;
   assign dma_rsp = rsp_q;

   // checks
   a_low_bits_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
      ((base_q & RSVD_MASK) == 32'h0) && ((limit_q & RSVD_MASK) == 32'h0))
      else $error("reserved low bits not zero");
   a_ro_when_absent: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      !regs_writable |=> $stable(base_q) && $stable(limit_q))
      else $error("region register changed while unsupported");
   a_base_write_takes: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
      (wr_w && hit_base && regs_writable && pstrb == 4'hF)
      |=> base_q == ($past(pwdata) & FIELD_MASK))
      else $error("base write lost");
   a_limit_write_takes: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
      (wr_w && hit_limit && regs_writable && pstrb == 4'hF)
      |=> limit_q == ($past(pwdata) & FIELD_MASK))
      else $error("limit write lost");
   a_block_in_range: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
      (dma_req.valid && sts_q && !remap_on && limit_q >= base_q
      && dma_req.addr >= (base_q & FIELD_MASK) && dma_req.addr <= (limit_q | RSVD_MASK))
      |=> dma_rsp.blocked)
      else $error("protected access not blocked");
   a_no_block_disabled: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
      (dma_req.valid && limit_q < base_q) |=> !dma_rsp.blocked)
      else $error("blocked while region disabled");
   a_no_block_outside: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
      (dma_req.valid && (dma_req.addr < dec_base || dma_req.addr > dec_limit))
      |=> !dma_rsp.blocked)
      else $error("blocked outside region");
   a_equal_size: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
      (base_q == limit_q) |-> (dec_limit - dec_base == RSVD_MASK))
      else $error("equal base and limit give wrong size");
   a_status_follows: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
      $rose(on_q) |=> sts_q ##0 en_rd[LOW_REGION_SUPPORTED_EN_STS_BIT])
      else $error("status did not follow enable");
   a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      setup_w |=> pready ##1 !pready || setup_w)
      else $error("apb ready timing wrong");

   // bus answer checks
   a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_w && !mapped_w) |=> pslverr)
      else $error("unmapped access not flagged");
   a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error shown without ready");
   a_ready_in_access: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> (psel && penable))
      else $error("ready outside access phase");
   a_no_setup_write: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_w && pwrite && hit_base) |=> $stable(base_q))
      else $error("write landed in setup cycle");
   a_base_readback: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
      (rd_w && hit_base) |=> (prdata == $past(base_q)))
      else $error("base readback wrong");
   a_limit_readback: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
      (rd_w && hit_limit) |=> (prdata == $past(limit_q)))
      else $error("limit readback wrong");
   a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_w && !mapped_w) |=> (prdata == 32'h0000_0000))
      else $error("unmapped read not zero");
   a_ro_readback: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      (rd_w && hit_base && !regs_writable) |=> (prdata == LOW_REGION_SUPPORTED_RESET_VAL))
      else $error("read-only base changed");
   a_status_readback: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
      (rd_w && hit_en) |=> (prdata[LOW_REGION_SUPPORTED_EN_STS_BIT] == $past(sts_q)))
      else $error("status readback wrong");
   a_status_clears: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
      $fell(on_q) |=> !sts_q)
      else $error("status did not clear");
   a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_w && hit_en && pstrb[ON_LANE]) |=> (on_q == $past(pwdata[LOW_REGION_SUPPORTED_EN_ON_BIT])))
      else $error("enable write lost");
   a_cap_low_bit: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      (rd_w && hit_cap) |=> (prdata[LOW_REGION_SUPPORTED_CAP_LOW_BIT] == LOW_SUPPORTED))
      else $error("capability bit wrong");

   // dma verdict checks
   a_no_block_remap: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
      (dma_req.valid && remap_on) |=> !dma_rsp.blocked)
      else $error("blocked while remapping on");
   a_no_block_off: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
      (dma_req.valid && !sts_q) |=> !dma_rsp.blocked)
      else $error("blocked while protection off");
   a_verdict_valid: assert property (@(posedge pclk) disable iff (!presetn)
      dma_req.valid |=> dma_rsp.valid)
      else $error("verdict missing");
   a_verdict_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !dma_req.valid |=> (!dma_rsp.valid && !dma_rsp.blocked))
      else $error("verdict without request");
endmodule : low_region_supported_region

// ===== test/low_region_supported_dma_src.sv
// dma requester model facing the region check
`timescale 1ns/1ps
module low_region_supported_dma_src
(
   // clock
   input wire logic pclk,
   // dma request and verdict
   output low_region_supported_pkg::low_region_supported_dma_req_t dma_req,
   input wire low_region_supported_pkg::low_region_supported_dma_rsp_t dma_rsp
);
   import low_region_supported_pkg::*;
   initial dma_req = '0;
   // idle address shows the inverse of the last one
   task automatic xfer(input logic [31:0] a, output low_region_supported_dma_rsp_t r);
      dma_req <= '{valid: 1'b1, addr: a};
      @(posedge pclk);
      dma_req <= '{valid: 1'b0, addr: ~a};
      @(posedge pclk);
      r = dma_rsp;
   endtask : xfer
endmodule : low_region_supported_dma_src

// ===== test/protected_low_memory_region_tb.sv
// self-checking bench for the protected low region
`timescale 1ns/1ps
module protected_low_memory_region_tb;
   import low_region_supported_pkg::*;
   localparam logic [31:0] MSK = (32'h0000_0002 << LOW_REGION_SUPPORTED_RSVD_N) - 32'h0000_0001;
   localparam logic [31:0] BS = 32'h0040_0000;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, remap_on, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, prdata_ro, r_ro;
   low_region_supported_dma_req_t dma_req;
   low_region_supported_dma_rsp_t dma_rsp, v;
   int err_total, check_count;
   low_region_supported_region u_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .remap_on(remap_on), .dma_req(dma_req),
      .dma_rsp(dma_rsp));
   low_region_supported_dma_src u_src(.pclk(pclk), .dma_req(dma_req), .dma_rsp(dma_rsp));
   // second copy without low-region support, same bus
   low_region_supported_region #(.LOW_SUPPORTED(1'b0)) u_ro(.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata_ro), .pready(), .pslverr(), .remap_on(remap_on), .dma_req(dma_req),
      .dma_rsp());
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] x, input string w);
      check_count++;
      if (s !== x)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", w, x, s);
      end
   endtask : chk
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      r_ro = prdata_ro;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(a, 1'b0, 32'h0);
      chk(r, x, "read data");
   endtask : rd
   task automatic dma(input logic [31:0] a, input logic b);
      u_src.xfer(a, v);
      chk({30'h0, v}, {30'h0, 1'b1, b}, "dma verdict");
   endtask : dma
   task automatic t_reg;
      rd(LOW_REGION_SUPPORTED_OFF_BASE, 32'h0);
      rd(LOW_REGION_SUPPORTED_OFF_LIMIT, 32'h0);
      apb(12'h0F0, 1'b0, 32'h0);
      chk({31'h0, e}, 32'h1, "unmapped error");
      apb(LOW_REGION_SUPPORTED_OFF_BASE, 1'b1, 32'hFFFF_FFFF);
      rd(LOW_REGION_SUPPORTED_OFF_BASE, ~MSK);
      chk(r_ro, 32'h0, "read-only base");
      apb(LOW_REGION_SUPPORTED_OFF_LIMIT, 1'b1, 32'hFFFF_FFFF);
      rd(LOW_REGION_SUPPORTED_OFF_LIMIT, ~MSK);
      chk(r_ro, 32'h0, "read-only limit");
      rd(LOW_REGION_SUPPORTED_OFF_CAP, 32'h1 << LOW_REGION_SUPPORTED_CAP_LOW_BIT);
      chk(r_ro, 32'h0, "capability without support");
      $display("registers test done");
   endtask : t_reg
   task automatic t_hit;
      apb(LOW_REGION_SUPPORTED_OFF_BASE, 1'b1, BS | 32'h0000_1234);
      apb(LOW_REGION_SUPPORTED_OFF_LIMIT, 1'b1, BS);
      apb(LOW_REGION_SUPPORTED_OFF_ENABLE, 1'b1, 32'h8000_0000);
      rd(LOW_REGION_SUPPORTED_OFF_ENABLE, 32'h8000_0001);
      dma(BS - 32'h1, 1'b0);
      dma(BS, 1'b1);
      dma(BS | MSK, 1'b1);
      dma(BS + MSK + 32'h1, 1'b0);
      remap_on <= 1'b1;
      dma(BS, 1'b0);
      remap_on <= 1'b0;
      $display("hit test done");
   endtask : t_hit
   task automatic t_off;
      apb(LOW_REGION_SUPPORTED_OFF_ENABLE, 1'b1, 32'h0);
      rd(LOW_REGION_SUPPORTED_OFF_ENABLE, 32'h0);
      dma(BS, 1'b0);
      apb(LOW_REGION_SUPPORTED_OFF_LIMIT, 1'b1, BS - MSK - 32'h1);
      apb(LOW_REGION_SUPPORTED_OFF_ENABLE, 1'b1, 32'h8000_0000);
      dma(BS - MSK - 32'h1, 1'b0);
      dma(BS, 1'b0);
      $display("disable test done");
   endtask : t_off
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test
   initial
   begin
      {presetn, psel, penable, pwrite, remap_on, paddr, pwdata} = '0;
      err_total = 0;
      check_count = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reg;
      t_hit;
      t_off;
      finish_test;
   end
   initial
   begin
      repeat (3000) @(posedge pclk);
      err_total++;
      finish_test;
   end
endmodule : protected_low_memory_region_tb
